// ==== core/cmd_seq_consts.svh ====
// Purpose: constants for the deferred command sequencer
// Assumes: ASCII command characters arrive one per strobe
// Notes:   commit steps are numbered as applied; step 6 is unused
//
// Behaviour
// - commands are parsed in character arrival order; deferred effects commit in step order
// - immediate commands act at once; deferred wait for the terminator
// - deferred commands store their effect in staging registers
// - a repeated deferred command keeps only its last occurrence
// - the execute character closes a line and bounds one batch
// - after an error, ignore everything through the next terminator; an unknown command ended by X also drops the whole next line
// - immediate commands finished by a following command before an error keep their effect
// - deferred effects of a line commit all or none
// - listed immediate commands are classed immediate
// - listed deferred commands are classed deferred
// - commit starts only after an error-free terminator
// - commit follows the fixed step order ending with trigger-on-command
// - step seven applies the last staged member of the channel setup group
// - acquisition starts only after trigger configuration commits
// - a parameter conflict lights the error flag and records code E4
// - command letters match in either case
// - codes of 32 or less are white space and split numbers
`ifndef CMD_SEQ_CONSTS_SVH
`define CMD_SEQ_CONSTS_SVH
`define WS_MAX      8'h20
`define CH_EXEC     8'h58
`define CH_STAR     8'h2a
`define CH_HASH     8'h23
`define CH_AT       8'h40
`define CH_QUERY    8'h3f
`define CH_COMMA    8'h2c
`define CH_CONFLICT 8'h21
`define CASE_BIT    5
`define ERR_CONFLICT 4'h4
`define ERR_SYNTAX   4'h1
`define STEP_COUNT  12
`define ARG_W       16
`endif

// ==== core/cmd_seq_pkg.sv ====
// Purpose: types for the deferred command sequencer
// Assumes: consts header holds all numbers
// Notes:   function indices follow the commit order
package cmd_seq_pkg;
  // staged function slots, in commit order (index 5 is the empty step)
  typedef enum logic [3:0] {
    FN_USER_TERM  = 4'h0,
    FN_QUERY_TERM = 4'h1,
    FN_FORMAT     = 4'h2,
    FN_EVENT_MASK = 4'h3,
    FN_TRIG_LEVEL = 4'h4,
    FN_SPARE      = 4'h5,
    FN_CHAN_SETUP = 4'h6,
    FN_TRIG_TIMES = 4'h7,
    FN_SCAN_INT   = 4'h8,
    FN_COUNTS     = 4'h9,
    FN_TRIG_CFG   = 4'ha,
    FN_TRIG_CMD   = 4'hb
  } fn_e;
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_PARSE  = 4'b0010,
    ST_SKIP   = 4'b0100,
    ST_COMMIT = 4'b1000
  } pstate_e;
  typedef logic [15:0] arg_t;
endpackage : cmd_seq_pkg

// ==== core/cmd_class_if.sv ====
// Purpose: classifier lookup bundle
// Assumes: single clock, combinational lookup
// Notes:   carries one decoded command
`timescale 1ns/1ps
`default_nettype none
interface cmd_class_if;
  logic [7:0] letter;
  logic       star;
  logic       hash;
  logic       known;
  logic       deferred;
  logic [3:0] fn;
  logic [3:0] sub;
  modport lookup (input letter, input star, input hash,
                  output known, output deferred, output fn, output sub);
  modport user (output letter, output star, output hash,
                input known, input deferred, input fn, input sub);
endinterface : cmd_class_if
`default_nettype wire

// ==== core/cmd_classifier.sv ====
// Purpose: classify a command as immediate or deferred
// Assumes: letter already folded to upper case
// Notes:   sub codes pick the member of the channel setup group
`timescale 1ns/1ps
`default_nettype none
`include "cmd_seq_consts.svh"
module cmd_classifier (
  cmd_class_if.lookup c
);
  import cmd_seq_pkg::*;
  logic       d;
  logic       k;
  logic [3:0] f;
  logic [3:0] s;
  always_comb begin
    d = 1'b0;
    k = 1'b1;
    f = FN_SPARE;
    s = 4'h0;
    if (c.star) begin
      unique case (c.letter)
        8'h43: begin d = 1'b1; f = FN_CHAN_SETUP; s = 4'h4; end
        8'h42, 8'h46, 8'h4b, 8'h50, 8'h52, 8'h53, 8'h54: d = 1'b0;
        default: k = 1'b0;
      endcase
    end else if (c.hash) begin
      unique case (c.letter)
        8'h41: begin d = 1'b1; f = FN_CHAN_SETUP; s = 4'h1; end
        8'h44: begin d = 1'b1; f = FN_CHAN_SETUP; s = 4'h5; end
        8'h46: begin d = 1'b1; f = FN_CHAN_SETUP; s = 4'h6; end
        8'h4d: begin d = 1'b1; f = FN_CHAN_SETUP; s = 4'h7; end
        8'h57: begin d = 1'b1; f = FN_CHAN_SETUP; s = 4'h8; end
        // input stamping joins the setup group
        8'h49: begin d = 1'b1; f = FN_CHAN_SETUP; s = 4'h2; end
        8'h43, 8'h52: d = 1'b0;
        default: k = 1'b0;
      endcase
    end else begin
      unique case (c.letter)
        `CH_AT: begin d = 1'b1; f = FN_TRIG_CMD; end
        8'h41:  begin d = 1'b1; f = FN_CHAN_SETUP; s = 4'h0; end
        8'h43:  begin d = 1'b1; f = FN_CHAN_SETUP; s = 4'h3; end
        8'h46:  begin d = 1'b1; f = FN_FORMAT; end
        8'h49:  begin d = 1'b1; f = FN_SCAN_INT; end
        8'h4c:  begin d = 1'b1; f = FN_TRIG_LEVEL; end
        8'h4e:  begin d = 1'b1; f = FN_EVENT_MASK; end
        8'h50:  begin d = 1'b1; f = FN_TRIG_TIMES; end
        8'h51:  begin d = 1'b1; f = FN_QUERY_TERM; end
        8'h54:  begin d = 1'b1; f = FN_TRIG_CFG; end
        8'h56:  begin d = 1'b1; f = FN_USER_TERM; end
        8'h59:  begin d = 1'b1; f = FN_COUNTS; end
        8'h45, 8'h47, 8'h48, 8'h4a, 8'h4b, 8'h4f, 8'h52, 8'h53, 8'h55, `CH_QUERY, `CH_EXEC: d = 1'b0;
        default: k = 1'b0;
      endcase
    end
  end
  assign c.known    = k;
  assign c.deferred = d;
  assign c.fn       = f;
  assign c.sub      = s;
endmodule : cmd_classifier
`default_nettype wire

// ==== core/deferred_command_sequencer.sv ====
// Purpose: ASCII command interpreter with staged deferred commit
// Assumes: one character per rx_valid strobe; host ends lines with X
// Notes:   commands finish when the next letter, X, * or @ arrives
`timescale 1ns/1ps
`default_nettype none
`include "cmd_seq_consts.svh"
module deferred_command_sequencer (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  // character stream
  input  wire logic              rx_valid,
  input  wire logic [7:0]        rx_char,
  output logic                   rx_ready,
  // immediate command strobe
  output logic                   imm_valid,
  output logic [7:0]             imm_cmd,
  output logic                   imm_star,
  output logic                   imm_hash,
  output cmd_seq_pkg::arg_t      imm_arg,
  // commit stream
  output logic                   apply_valid,
  output logic [3:0]             apply_fn,
  output logic [3:0]             apply_sub,
  output cmd_seq_pkg::arg_t      apply_arg,
  output logic                   acq_enable,
  // status
  output logic                   error_flag,
  output logic [3:0]             error_code,
  input  wire logic              error_query
);
  import cmd_seq_pkg::*;

  cmd_class_if cls ();
  cmd_classifier u_cls (.c(cls));

  pstate_e st_r;
  pstate_e st_nxt;
  logic [7:0]  cur_r;
  logic        star_r;
  logic        hash_r;
  logic        have_r;
  logic        in_num_r;
  logic        nsplit_r;
  arg_t        arg_r;
  logic [11:0] stg_v_r;
  arg_t        stg_a_r [12];
  logic [3:0]  stg_s_r [12];
  logic [3:0]  step_r;
  logic        stg_clr;
  logic        acq_r;
  logic        err_r;
  logic [3:0]  code_r;
  logic [7:0]  apply_cmd_r;
  logic        iv_r;
  logic        av_r;
  logic [3:0]  af_r;
  logic [3:0]  as_r;
  arg_t        aa_r;
  logic [7:0]  imc_r;
  logic        ims_r;
  logic        imh_r;
  arg_t        ima_r;

  wire [7:0] up_char  = (rx_char >= 8'h61 && rx_char <= 8'h7a) ? (rx_char & ~(8'h01 << `CASE_BIT)) : rx_char;
  wire       is_ws    = rx_char <= `WS_MAX;
  wire       is_dig   = rx_char >= 8'h30 && rx_char <= 8'h39;
  wire       is_let   = up_char >= 8'h41 && up_char <= 8'h5a;
  wire       is_exec  = up_char == `CH_EXEC;
  wire       is_sep   = is_ws || rx_char == `CH_COMMA || rx_char == 8'h2d || rx_char == 8'h3a || rx_char == 8'h2e;
  wire       starts   = is_let || rx_char == `CH_AT;
  wire       in_sp    = st_r == ST_PARSE;
  wire       take     = rx_valid && rx_ready;
  wire       bad_cmd  = have_r && !cls.known;
  // digit after split number is an error
  wire       bad_dig  = is_dig && nsplit_r;
  wire       conflict = rx_char == `CH_CONFLICT;
  wire       bad_chr  = !(is_dig || is_sep || starts || rx_char == `CH_STAR
                          || rx_char == `CH_HASH || rx_char == `CH_QUERY || conflict);
  wire       fin      = take && in_sp && (starts || rx_char == `CH_STAR) && have_r && !(star_r && cur_r == `CH_STAR);
  wire       err_now  = take && in_sp && (bad_dig || bad_chr || conflict || (fin && bad_cmd));
  wire [3:0] err_cd   = conflict ? `ERR_CONFLICT : `ERR_SYNTAX;

  assign cls.letter = cur_r;
  assign cls.star   = star_r;
  assign cls.hash   = hash_r;
  assign rx_ready   = st_r == ST_PARSE || st_r == ST_SKIP;

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_IDLE:   st_nxt = ST_PARSE;
      ST_PARSE:  if (err_now && !(is_exec && !bad_cmd)) st_nxt = ST_SKIP;
                 else if (take && is_exec && !err_now) st_nxt = ST_COMMIT;
                 else if (err_now) st_nxt = ST_PARSE;
      ST_SKIP:   if (take && is_exec) st_nxt = ST_PARSE;
      ST_COMMIT: if (step_r == 4'(`STEP_COUNT - 1)) st_nxt = ST_PARSE;
      default:   st_nxt = ST_IDLE;
    endcase
  end
  assign stg_clr = take && is_exec && (st_r == ST_SKIP || (in_sp && err_now));

  always_ff @(posedge ref_clk) begin
    if (!reset_n || (take && (is_exec || !in_sp))) begin
      have_r <= 1'b0; cur_r <= 8'h00; star_r <= 1'b0; hash_r <= 1'b0;
      arg_r <= '0; in_num_r <= 1'b0; nsplit_r <= 1'b0;
    end else if (take) begin
      if (rx_char == `CH_STAR) begin
        star_r <= 1'b1; cur_r <= `CH_STAR; have_r <= 1'b1; hash_r <= 1'b0; arg_r <= '0;
        in_num_r <= 1'b0; nsplit_r <= 1'b0;
      end else if (star_r && cur_r == `CH_STAR && is_let) begin
        cur_r <= up_char;
      end else if (starts) begin
        cur_r <= up_char; have_r <= 1'b1; star_r <= 1'b0; hash_r <= 1'b0;
        arg_r <= '0; in_num_r <= 1'b0; nsplit_r <= 1'b0;
      end else if (rx_char == `CH_HASH) begin
        hash_r <= 1'b1;
      end else if (is_dig) begin
        arg_r <= in_num_r ? 16'(arg_r * 16'd10 + 16'(rx_char - 8'h30)) : 16'(rx_char - 8'h30);
        in_num_r <= 1'b1;
      end else if (is_ws && in_num_r) begin
        nsplit_r <= 1'b1;
        in_num_r <= 1'b0;
      end else if (is_sep) begin
        in_num_r <= 1'b0;
        nsplit_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n || stg_clr || (st_r == ST_COMMIT && st_nxt == ST_PARSE)) begin
      stg_v_r <= '0;
    end else if (fin && !err_now && cls.deferred) begin
      stg_v_r[cls.fn] <= 1'b1;
      stg_a_r[cls.fn] <= arg_r;
      stg_s_r[cls.fn] <= cls.sub;
    end else if (take && is_exec && in_sp && !err_now && have_r && cls.deferred) begin
      stg_v_r[cls.fn] <= 1'b1;
      stg_a_r[cls.fn] <= arg_r;
      stg_s_r[cls.fn] <= cls.sub;
    end
  end

  wire imm_fire = in_sp && take && !err_now && have_r && cls.known && !cls.deferred && (fin || is_exec);

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      iv_r <= 1'b0; imc_r <= 8'h00; ims_r <= 1'b0; imh_r <= 1'b0; ima_r <= '0;
    end else begin
      iv_r <= imm_fire;
      if (imm_fire) begin
        imc_r <= cur_r; ims_r <= star_r; imh_r <= hash_r; ima_r <= arg_r;
      end
    end
  end

  wire step_live = st_r == ST_COMMIT && stg_v_r[step_r];
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st_r <= ST_IDLE; step_r <= 4'h0; av_r <= 1'b0; af_r <= 4'h0; as_r <= 4'h0; aa_r <= '0; acq_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      step_r <= (st_r == ST_COMMIT) ? 4'(step_r + 4'h1) : 4'h0;
      av_r   <= step_live;
      if (step_live) begin
        af_r <= step_r; as_r <= stg_s_r[step_r]; aa_r <= stg_a_r[step_r];
      end
      if (step_live && step_r == FN_TRIG_CFG) acq_r <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      err_r <= 1'b0; code_r <= 4'h0;
    end else if (err_now) begin
      err_r <= 1'b1; code_r <= err_cd;
    end else if (error_query) begin
      err_r <= 1'b0;
    end
  end

  assign imm_valid   = iv_r;
  assign imm_cmd     = imc_r;
  assign imm_star    = ims_r;
  assign imm_hash    = imh_r;
  assign imm_arg     = ima_r;
  assign apply_valid = av_r;
  assign apply_fn    = af_r;
  assign apply_sub   = as_r;
  assign apply_arg   = aa_r;
  assign acq_enable  = acq_r;
  assign error_flag  = err_r;
  assign error_code  = code_r;

  // nothing commits after an aborted line
  AST_SKIP_NO_COMMIT: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (st_r == ST_SKIP) |-> ##1 !(st_r == ST_COMMIT)) else $error("commit entered from skip");
  AST_ABORT_CLEAR: assert property (@(posedge ref_clk) disable iff (!reset_n)
    stg_clr |=> stg_v_r == 12'h000) else $error("staging not cleared");
  AST_ORDER: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (st_r == ST_COMMIT && $past(st_r) == ST_COMMIT) |-> step_r == 4'($past(step_r) + 4'h1)) else $error("step order");
  AST_COMMIT_AFTER_X: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (st_r == ST_COMMIT && $past(st_r) != ST_COMMIT) |-> $past(take && is_exec)) else $error("commit without X");
  AST_APPLY_IN_COMMIT: assert property (@(posedge ref_clk) disable iff (!reset_n)
    apply_valid |-> $past(st_r) == ST_COMMIT) else $error("apply outside commit");
  AST_ACQ_AFTER_TRIG: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(acq_enable) |-> $past(step_r) == FN_TRIG_CFG) else $error("acquisition early");
  AST_ERR_CODE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (err_now && conflict) |=> error_flag && error_code == `ERR_CONFLICT) else $error("conflict code");
  AST_NO_IMM_SKIP: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (st_r == ST_SKIP) |=> !imm_valid) else $error("immediate during skip");
endmodule : deferred_command_sequencer
`default_nettype wire

// ==== sim/host_model.sv ====
// Purpose: host side model sending ASCII command lines
// Assumes: rx_ready settles between clock edges
// Notes:   slow mode inserts random idle gaps
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // clock and handshake
  input  wire logic       ref_clk,
  input  wire logic       rx_ready,
  // character stream
  output logic            rx_valid,
  output logic [7:0]      rx_char
);
  initial begin
    rx_valid = 1'b0;
    rx_char  = 8'h00;
  end
  task automatic send_line(input string s, input int slow);
    string l;
    l = {s, "X"};
    for (int i = 0; i < l.len(); i++) begin
      if (slow != 0) begin
        rx_valid <= 1'b0;
        rx_char  <= ~rx_char;
        repeat ($urandom_range(3, 1)) @(posedge ref_clk);
      end
      rx_valid <= 1'b1;
      rx_char  <= l[i];
      @(negedge ref_clk);
      while (!rx_ready) @(negedge ref_clk);
      @(posedge ref_clk);
    end
    rx_valid <= 1'b0;
    rx_char  <= ~rx_char;
  endtask : send_line
endmodule : host_model
`default_nettype wire

// ==== sim/tb.sv ====
// Purpose: self-checking bench for the command sequencer
// Assumes: pulses sampled on the falling edge
// Notes:   reference model replays each line
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb;
  import cmd_seq_pkg::*;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        error_query = 1'b0;
  logic        rx_valid, rx_ready, imm_valid, imm_star, imm_hash, apply_valid, acq_enable, error_flag;
  logic [7:0]  rx_char, imm_cmd;
  logic [3:0]  apply_fn, apply_sub, error_code;
  arg_t        imm_arg, apply_arg;
  logic [25:0] exp_imm[$], obs_imm[$];
  logic [23:0] exp_app[$], obs_app[$];
  int          n_mismatch, tests_run, cycles;
  int          m_cmd, m_st, m_hs, m_arg, m_ns, m_err, m_on, acq_exp, err_exp, code_exp;
  int          stg_v[12], stg_s[12], stg_a[12];

  always #25 ref_clk = ~ref_clk;

  host_model u_host (.ref_clk(ref_clk), .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_char(rx_char));
  deferred_command_sequencer u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .rx_valid(rx_valid),
    .rx_char(rx_char), .rx_ready(rx_ready), .imm_valid(imm_valid), .imm_cmd(imm_cmd), .imm_star(imm_star),
    .imm_hash(imm_hash), .imm_arg(imm_arg), .apply_valid(apply_valid), .apply_fn(apply_fn),
    .apply_sub(apply_sub), .apply_arg(apply_arg), .acq_enable(acq_enable), .error_flag(error_flag),
    .error_code(error_code), .error_query(error_query));

  always @(negedge ref_clk) if (reset_n) begin
    if (imm_valid && imm_cmd !== "X") obs_imm.push_back({imm_cmd, imm_star, imm_hash, imm_arg});
    if (apply_valid) obs_app.push_back({apply_fn, apply_fn == 4'h6 ? apply_sub : 4'h0, apply_arg});
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  function automatic void fin();
    int fn, sb;
    fn = -1;
    sb = 0;
    if (m_on == 0) return;
    m_on = 0;
    if (m_st != 0) begin
      if (m_cmd == "C") begin fn = 6; sb = 4; end
    end else case (m_cmd)
      "V": fn = 0;
      "Q": fn = 1;
      "N": fn = 3;
      "L": fn = 4;
      "P": fn = 7;
      "Y": fn = 9;
      "T": fn = 10;
      "@": fn = 11;
      "F": begin fn = m_hs ? 6 : 2; sb = 6; end
      "I": begin fn = m_hs ? 6 : 8; sb = 2; end
      "A": begin fn = 6; sb = m_hs; end
      "C": if (m_hs == 0) begin fn = 6; sb = 3; end
      "D", "M", "W": if (m_hs != 0) begin fn = 6; sb = m_cmd == "D" ? 5 : m_cmd == "M" ? 7 : 8; end
      default: ;
    endcase
    if (fn < 0) exp_imm.push_back({8'(m_cmd), 1'(m_st), 1'(m_hs), 16'(m_arg)});
    else begin stg_v[fn] = 1; stg_s[fn] = sb; stg_a[fn] = m_arg; end
  endfunction : fin

  function automatic void model(input string s);
    logic [7:0] c;
    for (int i = 0; i < s.len(); i++) begin
      c = s[i];
      if (c >= "a" && c <= "z") c = c - 8'h20;
      if (c == "X") begin
        if (m_err == 0) begin
          fin();
          for (int f = 0; f < 12; f++) if (stg_v[f] != 0) begin
            exp_app.push_back({4'(f), f == 6 ? 4'(stg_s[f]) : 4'h0, 16'(stg_a[f])});
            if (f == 10) acq_exp = 1;
          end
        end
        m_err = 0;
        m_on = 0;
        foreach (stg_v[f]) stg_v[f] = 0;
      end else if (m_err != 0) ;
      else if (c == "!") begin m_err = 1; err_exp = 1; code_exp = 4; end
      else if (c >= "0" && c <= "9") begin
        if (m_ns == 2) begin m_err = 1; err_exp = 1; code_exp = 1; end
        else begin m_arg = ((m_ns != 0 ? m_arg * 10 : 0) + c - "0") & 16'hffff; m_ns = 1; end
      end else if (c <= 8'h20) begin if (m_ns == 1) m_ns = 2; end
      else if (c == ",") m_ns = 0;
      else if (c == "#") m_hs = 1;
      else if (c == "*") begin fin(); m_on = 1; m_st = 1; m_cmd = 0; m_hs = 0; m_arg = 0; m_ns = 0; end
      else if (m_on != 0 && m_st != 0 && m_cmd == 0) m_cmd = c;
      else begin fin(); m_on = 1; m_st = 0; m_cmd = c; m_hs = 0; m_arg = 0; m_ns = 0; end
    end
  endfunction : model

  task automatic run_test(input string s, input int slow);
    model({s, "X"});
    u_host.send_line(s, slow);
    repeat (24) @(posedge ref_clk);
    `CHK("imm count", exp_imm.size(), obs_imm.size())
    foreach (exp_imm[i]) `CHK("imm", exp_imm[i], obs_imm[i])
    `CHK("apply count", exp_app.size(), obs_app.size())
    foreach (exp_app[i]) `CHK("apply", exp_app[i], obs_app[i])
    `CHK("acq", 1'(acq_exp), acq_enable)
    `CHK("err", 1'(err_exp), error_flag)
    `CHK("code", 4'(code_exp), error_code)
    if (err_exp != 0) begin
      error_query <= 1'b1;
      @(posedge ref_clk);
      error_query <= 1'b0;
      @(posedge ref_clk);
      `CHK("err clear", 1'b0, error_flag)
      err_exp = 0;
    end
    $display("test done: %s", s);
    exp_imm.delete();
    obs_imm.delete();
    exp_app.delete();
    obs_app.delete();
  endtask : run_test

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  initial begin
    void'($urandom(32'h1a62fb2b));
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    run_test("F1,1 L 4 F1,3", 0);
    run_test("*K12 O3 C#2 k5 g7", 1);
    run_test("@1 T2 Y3 I4 P5 W#6 L7 N8 F9 Q10 V11", 0);
    run_test("A1 C2 *C3 D#4 M#5", 1);
    run_test("O5 F2 !O6 N3", 0);
    run_test("N7", 0);
    run_test("F1 2 O9", 0);
    for (int k = 0; k < 4; k++)
      run_test($sformatf("O%0d f%0d Y%0d,%0d", $urandom_range(9999), $urandom_range(9999),
               $urandom_range(9), $urandom_range(9999)), 1);
    end_of_test();
  end
endmodule : tb
`default_nettype wire
